//--- dcr_core.sv
// two-channel reservation and forced takeover logic
`timescale 1ns/10ps
`default_nettype none
// Operation
// - deselect starts 500 ms timer; expiry clears reservation only under timed hold, never lockout
// - timed hold option: timer expiry clears reservation, drive free
// - absolute hold option: expiry ignored, reservation kept until release or takeover
// - release clears reservation and the other channel's lockout
// - other channel admitted only after releaser drops select and deselects
// - takeover locks owner out, clears its state, chooses and reserves requester
// - locked-out channel stays so until other channel releases
// - both disable switches in disable position lock the channel
// - available drive with matching address answers unit chosen
// - drive held by other channel answers chosen plus busy, no grant
// - after refused attempt, seek done low 30 us once drive freed
// - chosen states set on alternate 5 MHz phases
module dcr_core import dcr_pkg::*; #(
	parameter int unsigned RELEASE_COUNT = RELEASE_CYCLES
) (
	input  wire logic              mclk,
	input  wire logic              reset,
	input  wire logic [ADDR_W-1:0] logical_address,
	input  wire logic              absolute_hold_option,
	input  wire logic              timed_hold_option,
	input  wire dcr_chan_in_type   chan_in_0,
	input  wire dcr_chan_in_type   chan_in_1,
	output var  dcr_chan_out_type  chan_out_0,
	output var  dcr_chan_out_type  chan_out_1
);
	////////////////////////////////////////////////////////////////////////////
	// parameter checks
	if (RELEASE_COUNT < 1) begin : g_bad_release
		$error("dcr_core: RELEASE_COUNT must be at least one");
	end
	if (PHASE_CYCLES < 1) begin : g_bad_phase
		$error("dcr_core: phase half period must be at least one cycle");
	end
	if (NOTICE_CYCLES < 1) begin : g_bad_notice
		$error("dcr_core: availability notice must be at least one cycle");
	end

	////////////////////////////////////////////////////////////////////////////
	// input registers
	dcr_chan_in_type in_q [2];

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			in_q[0] <= '0;
			in_q[1] <= '0;
		end else begin
			in_q[0] <= chan_in_0;
			in_q[1] <= chan_in_1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// decode
	logic [1:0] chosen_q;
	logic [1:0] reservation_state_q;
	logic [1:0] channel_lockout_state_q;
	logic [1:0] tried_q;
	logic [1:0] switch_off;
	logic [1:0] blocked;
	logic [1:0] match;
	logic [1:0] takeover;
	logic [1:0] release_cmd;
	logic [1:0] held_other;
	logic [1:0] expire;
	logic [1:0] freed;
	logic [1:0] grant;
	logic [1:0] refused;
	logic       phase_q;
	logic [$clog2(PHASE_CYCLES+1)-1:0] phase_cnt_q;

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			switch_off[c]  = (in_q[c].disable_switch_n == 2'h0);
			blocked[c]     = switch_off[c] | channel_lockout_state_q[c];
			match[c]       = in_q[c].unit_select && !blocked[c] &&
				(in_q[c].address == logical_address);
			held_other[c]  = chosen_q[1-c] | reservation_state_q[1-c];
			takeover[c]    = match[c] && in_q[c].bus_out[BIT_FORCE] &&
				held_other[c] && !chosen_q[c];
			release_cmd[c] = (in_q[c].tag == TAG_CONTROL) && in_q[c].bus_out[BIT_FORCE] &&
				chosen_q[c];
			freed[c]       = tried_q[c] && !held_other[c];
			grant[c]       = match[c] && !chosen_q[c] && !held_other[c];
			refused[c]     = match[c] && held_other[c] && !takeover[c];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// alternate phase generator
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			phase_cnt_q <= '0;
			phase_q     <= 1'b0;
		end else if (phase_cnt_q == ($bits(phase_cnt_q))'(PHASE_CYCLES - 1)) begin
			phase_cnt_q <= '0;
			phase_q     <= ~phase_q;
		end else begin
			phase_cnt_q <= phase_cnt_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// chosen, reservation and lockout state
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			chosen_q                <= '0;
			reservation_state_q     <= '0;
			channel_lockout_state_q <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (release_cmd[c]) begin
					reservation_state_q[c]       <= 1'b0;
					channel_lockout_state_q[1-c] <= 1'b0;
				end
				if (expire[c] && timed_hold_option && !absolute_hold_option) begin
					reservation_state_q[c] <= 1'b0;
				end
				if (!in_q[c].unit_select || blocked[c]) begin
					chosen_q[c] <= 1'b0;
				end
				if (phase_q == c[0]) begin
					if (takeover[c]) begin
						channel_lockout_state_q[1-c] <= 1'b1;
						reservation_state_q[1-c]     <= 1'b0;
						chosen_q[c]                  <= 1'b1;
						reservation_state_q[c]       <= 1'b1;
					end else if (grant[c]) begin
						chosen_q[c]            <= 1'b1;
						reservation_state_q[c] <= 1'b1;
					end
				end
				if (takeover[1-c] && phase_q != c[0]) begin
					chosen_q[c] <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// release timers and availability notice
	logic [1:0] chosen_prev_q;
	logic [1:0] notice_run;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			chosen_prev_q <= '0;
			tried_q       <= '0;
		end else begin
			chosen_prev_q <= chosen_q;
			for (int c = 0; c < 2; c++) begin
				if (freed[c]) begin
					tried_q[c] <= 1'b0;
				end
				if (refused[c]) begin
					tried_q[c] <= 1'b1;
				end
			end
		end
	end

	for (genvar g = 0; g < 2; g++) begin : g_chan
		dcr_pulse_timer #(
			.COUNT (RELEASE_COUNT)
		) u_release (
			.mclk    (mclk),
			.reset   (reset),
			.start   (chosen_prev_q[g] && !chosen_q[g]),
			.cancel  (chosen_q[g]),
			.running (),
			.expired (expire[g])
		);
		dcr_pulse_timer #(
			.COUNT (NOTICE_CYCLES)
		) u_notice (
			.mclk    (mclk),
			.reset   (reset),
			.start   (freed[g]),
			.cancel  (1'b0),
			.running (notice_run[g]),
			.expired ()
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// registered outputs
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			chan_out_0.unit_chosen <= 1'b0;
			chan_out_0.busy        <= 1'b0;
			chan_out_0.seek_done_n <= 1'b1;
			chan_out_0.chosen      <= 1'b0;
			chan_out_0.reserved    <= 1'b0;
			chan_out_0.lockout     <= 1'b0;
			chan_out_1.unit_chosen <= 1'b0;
			chan_out_1.busy        <= 1'b0;
			chan_out_1.seek_done_n <= 1'b1;
			chan_out_1.chosen      <= 1'b0;
			chan_out_1.reserved    <= 1'b0;
			chan_out_1.lockout     <= 1'b0;
		end else begin
			chan_out_0.unit_chosen <= match[0];
			chan_out_0.busy        <= refused[0];
			chan_out_0.seek_done_n <= !notice_run[0];
			chan_out_0.chosen      <= chosen_q[0];
			chan_out_0.reserved    <= reservation_state_q[0];
			chan_out_0.lockout     <= blocked[0];
			chan_out_1.unit_chosen <= match[1];
			chan_out_1.busy        <= refused[1];
			chan_out_1.seek_done_n <= !notice_run[1];
			chan_out_1.chosen      <= chosen_q[1];
			chan_out_1.reserved    <= reservation_state_q[1];
			chan_out_1.lockout     <= blocked[1];
		end
	end
endmodule
`default_nettype wire

//--- dcr_pkg.sv
// constants and types for the dual channel reservation block
package dcr_pkg;

	localparam int unsigned CLK_HZ          = 50_000_000;
	localparam int unsigned RELEASE_MS      = 500;
	localparam int unsigned RELEASE_CYCLES  = CLK_HZ / 1000 * RELEASE_MS;
	localparam int unsigned NOTICE_US       = 30;
	localparam int unsigned NOTICE_CYCLES   = CLK_HZ / 1_000_000 * NOTICE_US;
	localparam int unsigned PHASE_HZ        = 5_000_000;
	localparam int unsigned PHASE_CYCLES    = CLK_HZ / PHASE_HZ / 2;
	localparam int unsigned ADDR_W          = 3;
	localparam int unsigned BUS_OUT_W       = 10;
	localparam int unsigned BIT_FORCE       = 9;
	localparam int unsigned TAG_W           = 3;
	localparam logic [2:0]  TAG_CONTROL     = 3'h3;

	typedef struct packed {
		logic                  unit_select;
		logic [TAG_W-1:0]      tag;
		logic [BUS_OUT_W-1:0]  bus_out;
		logic [ADDR_W-1:0]     address;
		logic [1:0]            disable_switch_n;
	} dcr_chan_in_type;

	typedef struct packed {
		logic unit_chosen;
		logic busy;
		logic seek_done_n;
		logic chosen;
		logic reserved;
		logic lockout;
	} dcr_chan_out_type;

endpackage

//--- dcr_pulse_timer.sv
// one-shot down counter used for release interval and availability notice
`timescale 1ns/10ps
`default_nettype none
module dcr_pulse_timer #(
	parameter int unsigned COUNT = 16
) (
	input  wire logic mclk,
	input  wire logic reset,
	input  wire logic start,
	input  wire logic cancel,
	output var  logic running,
	output var  logic expired
);
	localparam int unsigned W = (COUNT < 2) ? 1 : $clog2(COUNT + 1);
	logic [W-1:0] count_q;

	initial begin
		if (COUNT < 1) begin
			$error("dcr_pulse_timer: COUNT must be at least one");
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			count_q <= '0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (cancel) begin
				count_q <= '0;
			end else if (start) begin
				count_q <= W'(COUNT);
			end else if (count_q != '0) begin
				count_q <= count_q - W'(1);
				if (count_q == W'(1)) begin
					expired <= 1'b1;
				end
			end
		end
	end

	assign running = (count_q != '0);
endmodule
`default_nettype wire

//--- dcr_assertions.sv
// checker for the dual channel reservation block
`timescale 1ns/10ps
`default_nettype none
module dcr_assertions import dcr_pkg::*; (
	input wire logic              mclk,
	input wire logic              reset,
	input wire logic [ADDR_W-1:0] logical_address,
	input wire logic              absolute_hold_option,
	input wire logic              timed_hold_option,
	input wire dcr_chan_in_type   chan_in_0,
	input wire dcr_chan_in_type   chan_in_1,
	input wire dcr_chan_out_type  chan_out_0,
	input wire dcr_chan_out_type  chan_out_1
);
	dcr_chan_in_type  i0;
	dcr_chan_in_type  i1;
	dcr_chan_out_type o0;
	dcr_chan_out_type o1;
	assign i0 = chan_in_0;
	assign i1 = chan_in_1;
	assign o0 = chan_out_0;
	assign o1 = chan_out_1;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////////////////////
	a_one_owner: assert property (!(o0.chosen && o1.chosen))
		else $error("both channels chosen");
	a_switch_lock: assert property ((i0.disable_switch_n == 2'h0)[*3] |->
		o0.lockout && !o0.unit_chosen) else $error("switch disable ignored");
	a_busy_ack: assert property (o1.busy |-> o1.unit_chosen && !o1.chosen)
		else $error("busy without ack or with grant");
	a_idle_no_ack: assert property ((!i0.unit_select)[*3] |-> !o0.unit_chosen)
		else $error("ack without select");
	a_absolute_keep: assert property ((absolute_hold_option && !i0.unit_select
		&& !i1.unit_select)[*3] ##0 o0.reserved |=> o0.reserved)
		else $error("absolute reservation dropped");
	a_notice_len: assert property ($fell(o1.seek_done_n) |-> (!o1.seek_done_n)[*8])
		else $error("notice too short");
	a_grant_cause: assert property ($rose(o0.chosen) |-> $past(i0.unit_select, 3))
		else $error("chosen without select");
	a_force_locks: assert property (i1.unit_select && i1.bus_out[BIT_FORCE] && o0.chosen
		&& i1.address == logical_address && !o1.chosen && !o1.lockout
		&& i1.disable_switch_n != 2'h0
		|-> ##[1:14] o0.lockout) else $error("takeover did not lock owner out");
endmodule
bind dcr_core dcr_assertions dcr_assertions_i (.mclk, .reset, .logical_address,
	.absolute_hold_option, .timed_hold_option, .chan_in_0, .chan_in_1,
	.chan_out_0, .chan_out_1);
`default_nettype wire

//--- dcr_ctrl_model.sv
// controller on one drive channel: idle, select, release, force
`timescale 1ns/10ps
`default_nettype none
module dcr_ctrl_model import dcr_pkg::*; (
	input wire logic [1:0]        cmd,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic              sw_off,
	output var dcr_chan_in_type   ci
);
	always_comb begin
		ci.unit_select      = cmd != 2'h0;
		ci.tag              = cmd == 2'h2 ? TAG_CONTROL : 3'h0;
		ci.bus_out          = {cmd[1], 9'h0};
		ci.address          = cmd != 2'h0 ? addr : ~addr;
		ci.disable_switch_n = sw_off ? 2'h0 : 2'h3;
	end
endmodule
`default_nettype wire

//--- tb.sv
// testbench for the dual channel reservation block
`timescale 1ns/10ps
`default_nettype none
module tb import dcr_pkg::*;;
	logic mclk = 1'b0, reset = 1'b1, abs_opt = 1'b1, tim_opt = 1'b0, sw0 = 1'b0, sw1 = 1'b0;
	logic [1:0] cmd0 = 2'h0, cmd1 = 2'h0;
	int n_errors = 0, comparisons = 0, cycles = 0;
	dcr_chan_in_type ci0, ci1;
	dcr_chan_out_type o0, o1;
	always #10 mclk = ~mclk;
	dcr_ctrl_model dcr_ctrl_model_i (.cmd(cmd0), .addr(3'h5), .sw_off(sw0), .ci(ci0));
	dcr_ctrl_model dcr_ctrl_model_i_1 (.cmd(cmd1), .addr(3'h5), .sw_off(sw1), .ci(ci1));
	dcr_core #(.RELEASE_COUNT(50)) dcr_core_i (.mclk, .reset, .logical_address(3'h5),
		.absolute_hold_option(abs_opt), .timed_hold_option(tim_opt),
		.chan_in_0(ci0), .chan_in_1(ci1), .chan_out_0(o0), .chan_out_1(o1));
	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(string name, logic exp, logic got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %b seen %b", name, exp, got);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge mclk);
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 6000) begin
			n_errors++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(3);
		reset = 1'b0;
		chk("seek_done_n0", 1'b1, o0.seek_done_n);
		cmd0 = 2'h1; cyc(14);
		chk("unit_chosen0", 1'b1, o0.unit_chosen);
		chk("reserved0", 1'b1, o0.reserved);
		cmd1 = 2'h1; cyc(4);
		chk("busy1", 1'b1, o1.busy);
		chk("chosen1", 1'b0, o1.chosen);
		cmd1 = 2'h0; cmd0 = 2'h0; cyc(80);
		chk("absolute reserved0", 1'b1, o0.reserved);
		cmd0 = 2'h1; cyc(14);
		cmd0 = 2'h2; cmd1 = 2'h1; cyc(4);
		chk("held chosen1", 1'b0, o1.chosen);
		chk("held busy1", 1'b1, o1.busy);
		cmd0 = 2'h0; cyc(14);
		chk("released0", 1'b0, o0.reserved);
		chk("admitted1", 1'b1, o1.chosen);
		chk("notice1", 1'b0, o1.seek_done_n);
		cyc(1600);
		chk("notice1 end", 1'b1, o1.seek_done_n);
		abs_opt = 1'b0; tim_opt = 1'b1; cmd1 = 2'h1; cyc(14);
		cmd1 = 2'h0; cyc(20);
		chk("timed early reserved1", 1'b1, o1.reserved);
		cmd1 = 2'h1; cyc(14);
		cmd1 = 2'h0; cyc(40);
		chk("reselect cancels reserved1", 1'b1, o1.reserved);
		cyc(60);
		chk("timed expired reserved1", 1'b0, o1.reserved);
		cmd0 = 2'h1; cyc(14);
		cmd1 = 2'h3; cyc(14);
		chk("lockout0", 1'b1, o0.lockout);
		chk("chosen0", 1'b0, o0.chosen);
		chk("reserved1", 1'b1, o1.reserved);
		cmd1 = 2'h1; cyc(14);
		chk("locked ack0", 1'b0, o0.unit_chosen);
		chk("locked busy0", 1'b0, o0.busy);
		chk("owner ack1", 1'b1, o1.unit_chosen);
		chk("owner busy1", 1'b0, o1.busy);
		chk("owner lockout1", 1'b0, o1.lockout);
		cmd0 = 2'h0; cmd1 = 2'h2; cyc(4);
		cmd1 = 2'h0; cyc(14);
		chk("unlocked0", 1'b0, o0.lockout);
		sw0 = 1'b1; cmd0 = 2'h1; cyc(14);
		chk("switch lockout0", 1'b1, o0.lockout);
		chk("switch ack0", 1'b0, o0.unit_chosen);
		sw0 = 1'b0; cmd0 = 2'h0; cyc(4);
		finish_test();
	end
endmodule
`default_nettype wire
